// [common/flash_protect_defines.vh]
/*
  Constants shared by the flash protection command logic: fixed opcodes,
  security register bit positions, reset values and recovery timing.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef FLASH_PROTECT_DEFINES_VH
`define FLASH_PROTECT_DEFINES_VH

// Fixed command opcodes.
`define OPC_WRITE_ENABLE     8'h06
`define OPC_SEC_REG_WRITE    8'h2F
`define OPC_PROTECT_SELECT   8'h68
`define OPC_REGION_LOCK      8'h36
`define OPC_REGION_UNLOCK    8'h39
`define OPC_LOCK_STATUS_READ 8'h3C
`define OPC_GANG_LOCK        8'h7E
`define OPC_GANG_UNLOCK      8'h98

// Default opcodes of the commands whose codes are design parameters.
`define OPC_RB_ENABLE_DEF    8'h70
`define OPC_RB_DISABLE_DEF   8'h80
`define OPC_NOP_DEF          8'h00
`define OPC_RESET_ARM_DEF    8'h66
`define OPC_RESET_DEF        8'h99

// Security register bit positions.
`define SEC_BIT_SCHEME       7
`define SEC_BIT_CONTINUOUS_PROGRAM_MODE      4
`define SEC_BIT_LOCKDOWN     1

// Reset values.
`define RST_SCHEME           1'b0
`define RST_LOCKDOWN         1'b0
`define RST_REGION_LOCK      1'b1

// Address bytes carried by the region commands.
`define ADDR_BYTES           3'h3

// Recovery timing after a software reset.
`define CLK_PERIOD_NS        8
`define T_RCV_PROGRAM_NS     40000
`define T_RCV_OTHER_NS       12000

`endif

// [src/serial_frame_rx.v]
/*
  Serial frame receiver: brings chip select, serial clock and serial input
  into the core clock domain and cuts the input stream into bytes.
  Assumes the serial clock runs well below a quarter of the core clock.
*/
`timescale 1ns/10ps
module serial_frame_rx (
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       cs_n_pin,
  input  wire       sclk_pin,
  input  wire       si_pin,
  output wire       frame_start,
  output wire       frame_end,
  output wire       end_aligned,
  output wire       sclk_rise,
  output wire       sclk_fall,
  output wire       byte_valid,
  output wire [7:0] byte_data,
  output wire       cs_active
);

  reg       cs_s1_q;
  reg       cs_s2_q;
  reg       cs_s3_q;
  reg       sclk_s1_q;
  reg       sclk_s2_q;
  reg       sclk_s3_q;
  reg       si_s1_q;
  reg       si_s2_q;
  reg [2:0] bit_cnt_q;
  reg [6:0] shift_q;

  // Two flip-flops per pin; the third stage only serves the edge detectors.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      si_s1_q   <= 1'b0;
      si_s2_q   <= 1'b0;
    end else begin
      cs_s1_q   <= cs_n_pin;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      sclk_s1_q <= sclk_pin;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      si_s1_q   <= si_pin;
      si_s2_q   <= si_s1_q;
    end
  end

  assign cs_active   = ~cs_s2_q;
  assign frame_start = ~cs_s2_q & cs_s3_q;
  assign frame_end   = cs_s2_q & ~cs_s3_q;
  assign sclk_rise   = sclk_s2_q & ~sclk_s3_q & ~cs_s2_q;
  assign sclk_fall   = ~sclk_s2_q & sclk_s3_q & ~cs_s2_q;
  assign end_aligned = (bit_cnt_q == 3'h0);
  assign byte_valid  = sclk_rise & (bit_cnt_q == 3'h7);
  assign byte_data   = {shift_q, si_s2_q};

  // Bits arrive most significant first; the count restarts with each frame.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else if (frame_start) begin
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], si_s2_q};
    end
  end

endmodule // serial_frame_rx

// [src/flash_protect_cmd_logic.v]
/*
  Protection command logic of a serial flash: security register write,
  protection scheme selection, region locks, lock status readback,
  ready/busy output control and the two-step software reset.
  Assumes the host drives chip select, serial clock and serial input as
  an ordinary serial flash master, and that the array engine reports its
  busy, program and erase state on plain inputs.
*/
`timescale 1ns/10ps
`include "flash_protect_defines.vh"

// Overview of operation
// - Security register write only sets the lockdown bit; lockdown freezes OTP area.
// - Protection write commands run only after a write enable command.
// - Write commands and ready/busy commands need chip select rising on a byte boundary.
// - Scheme flag 0 (default) picks range protection, 1 picks per-region locks.
// - Scheme flag can be set once and never returns to 0.
// - Protection select sets security bit 7 and enables the region commands.
// - Range bits and region locks never act at the same time.
// - Range mode protects by the four range bits of the status register.
// - Every region lock bit powers up as 1.
// - Locked regions refuse program and erase until unlocked.
// - Region and gang lock commands are ignored before protection select.
// - Region lock sets, region unlock clears one lock bit; three address bytes.
// - Region chosen by A21-A16 for blocks, A21-A12 for sectors (BLOCK_AW of 6).
// - Lock status read returns the region lock bit in the first output byte.
// - Lock status read works only after protection select.
// - Gang lock sets all lock bits, gang unlock clears all; opcode only.
// - Ready/busy enable drives busy state on the output during continuous program.
// - Ready/busy disable stops that drive.
// - No-operation only cancels a pending reset arm.
// - Reset runs only directly after reset arm; any other command cancels arm.
// - Software reset returns to standby and aborts program or erase.
// - Recovery after reset is longer after program than after other work.
// - Only the serial input and output carry command traffic.
// - Once locked down, neither the lockdown bit nor the OTP area changes.
module flash_protect_cmd_logic #(
  parameter       BLOCK_AW        = 6,
  parameter [7:0] OPC_RB_ENABLE   = `OPC_RB_ENABLE_DEF,
  parameter [7:0] OPC_RB_DISABLE  = `OPC_RB_DISABLE_DEF,
  parameter [7:0] OPC_NOP         = `OPC_NOP_DEF,
  parameter [7:0] OPC_RESET_ARM   = `OPC_RESET_ARM_DEF,
  parameter [7:0] OPC_RESET       = `OPC_RESET_DEF,
  parameter       RCV_PROGRAM_CYC = `T_RCV_PROGRAM_NS / `CLK_PERIOD_NS,
  parameter       RCV_OTHER_CYC   = `T_RCV_OTHER_NS / `CLK_PERIOD_NS
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire        si_pin,
  input  wire [3:0]  range_protect_bits,
  input  wire        continuous_program_mode,
  input  wire        dev_busy,
  input  wire        program_active,
  input  wire        erase_active,
  input  wire [23:0] check_addr,
  output reg         so_out,
  output reg         so_oe_n,
  output reg         protect_scheme_select,
  output reg         otp_lockdown_bit,
  output reg         otp_write_ok,
  output reg         region_write_ok,
  output reg         write_enable_latch,
  output reg         ready_busy_out_en,
  output reg         sw_reset_pulse,
  output reg         op_abort_pulse,
  output reg         reset_recovering,
  output reg         cmd_reject_pulse
);

  localparam NUM_BLOCKS = 1 << BLOCK_AW;
  localparam CNT_W      = 20;

  // One-hot command states.
  localparam [3:0] ST_OPCODE = 4'h1;
  localparam [3:0] ST_ADDR   = 4'h2;
  localparam [3:0] ST_READ   = 4'h4;
  localparam [3:0] ST_SKIP   = 4'h8;

  wire       frame_start;
  wire       frame_end;
  wire       end_aligned;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       byte_valid;
  wire [7:0] byte_data;
  wire       cs_active;

  reg  [3:0]          state_q;
  reg  [3:0]          state_d;
  reg  [7:0]          opcode_q;
  reg                 have_opc_q;
  reg  [2:0]          addr_cnt_q;
  reg                 extra_q;
  reg  [23:0]         addr_q;
  reg  [7:0]          out_shift_q;
  reg                 reset_armed_q;
  reg  [NUM_BLOCKS-1:0] block_lock_q;
  reg  [31:0]         sector_lock_q;
  reg  [CNT_W-1:0]    rcv_cnt_q;

  // Byte framing of the serial input; upper data pins are not sampled.
  serial_frame_rx u_rx (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .cs_n_pin    (cs_n_pin),
    .sclk_pin    (sclk_pin),
    .si_pin      (si_pin),
    .frame_start (frame_start),
    .frame_end   (frame_end),
    .end_aligned (end_aligned),
    .sclk_rise   (sclk_rise),
    .sclk_fall   (sclk_fall),
    .byte_valid  (byte_valid),
    .byte_data   (byte_data),
    .cs_active   (cs_active)
  );

  // Command classes. Every byte count must match exactly for a write.
  wire is_write_enable_cmd    = (opcode_q == `OPC_WRITE_ENABLE);
  wire is_secw    = (opcode_q == `OPC_SEC_REG_WRITE);
  wire is_psel    = (opcode_q == `OPC_PROTECT_SELECT);
  wire is_lock    = (opcode_q == `OPC_REGION_LOCK);
  wire is_unlock  = (opcode_q == `OPC_REGION_UNLOCK);
  wire is_rdlock  = (opcode_q == `OPC_LOCK_STATUS_READ);
  wire is_glock   = (opcode_q == `OPC_GANG_LOCK);
  wire is_gunlock = (opcode_q == `OPC_GANG_UNLOCK);
  wire is_rb_en   = (opcode_q == OPC_RB_ENABLE);
  wire is_rb_dis  = (opcode_q == OPC_RB_DISABLE);
  wire is_reset   = (opcode_q == OPC_RESET);
  wire is_arm     = (opcode_q == OPC_RESET_ARM);
  wire is_wr_cmd  = is_secw | is_psel | is_lock | is_unlock | is_glock | is_gunlock;

  // A frame counts only if an opcode arrived and the device is not recovering.
  wire frame_done = frame_end & have_opc_q & ~reset_recovering;
  wire no_addr_ok = end_aligned & ~extra_q & (addr_cnt_q == 3'h0);
  wire addr_ok    = end_aligned & ~extra_q & (addr_cnt_q == `ADDR_BYTES);
  wire wr_gate    = write_enable_latch & frame_done;
  wire exec_secw  = wr_gate & is_secw & no_addr_ok & ~otp_lockdown_bit;
  wire exec_psel  = wr_gate & is_psel & no_addr_ok;
  wire region_ok  = wr_gate & protect_scheme_select & addr_ok;
  wire gang_ok    = wr_gate & protect_scheme_select & no_addr_ok;
  wire exec_lock  = region_ok & is_lock;
  wire exec_unlk  = region_ok & is_unlock;
  wire exec_glock = gang_ok & is_glock;
  wire exec_gunlk = gang_ok & is_gunlock;
  wire exec_reset = frame_done & is_reset & reset_armed_q & no_addr_ok;
  wire any_exec   = exec_secw | exec_psel | exec_lock | exec_unlk | exec_glock | exec_gunlk;

  // Region decode: the first and last blocks are split into 4K sectors.
  function region_locked;
    input [23:0]          a;
    input [NUM_BLOCKS-1:0] blk;
    input [31:0]          sec;
    reg   [BLOCK_AW-1:0]  b;
    begin
      b = a[16 +: BLOCK_AW];
      if (b == {BLOCK_AW{1'b0}})
        region_locked = sec[{1'b0, a[15:12]}];
      else if (b == {BLOCK_AW{1'b1}})
        region_locked = sec[{1'b1, a[15:12]}];
      else
        region_locked = blk[b];
    end
  endfunction

  wire [BLOCK_AW-1:0] tgt_block = addr_q[16 +: BLOCK_AW];
  wire                tgt_first = (tgt_block == {BLOCK_AW{1'b0}});
  wire                tgt_last  = (tgt_block == {BLOCK_AW{1'b1}});
  wire [4:0]          tgt_sec   = {tgt_last, addr_q[15:12]};

  // Command state machine; bytes past what a command takes are noted.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OPCODE: if (byte_valid)
          state_d = ((byte_data == `OPC_REGION_LOCK) | (byte_data == `OPC_REGION_UNLOCK) |
                     (byte_data == `OPC_LOCK_STATUS_READ)) ? ST_ADDR : ST_SKIP;
      ST_ADDR: if (byte_valid && addr_cnt_q == 3'h2)
          state_d = is_rdlock ? ST_READ : ST_SKIP;
      ST_READ: state_d = ST_READ;
      ST_SKIP: state_d = ST_SKIP;
      default: state_d = ST_OPCODE;
    endcase
    if (frame_start | ~cs_active)
      state_d = ST_OPCODE;
  end

  // Opcode, address and byte count capture for the current frame.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q    <= ST_OPCODE;
      opcode_q   <= 8'h00;
      have_opc_q <= 1'b0;
      addr_cnt_q <= 3'h0;
      extra_q    <= 1'b0;
      addr_q     <= 24'h000000;
    end else begin
      state_q <= state_d;
      if (frame_start) begin
        have_opc_q <= 1'b0;
        addr_cnt_q <= 3'h0;
        extra_q    <= 1'b0;
      end else if (byte_valid) begin
        if (state_q == ST_OPCODE) begin
          opcode_q   <= byte_data;
          have_opc_q <= 1'b1;
        end else if (state_q == ST_ADDR) begin
          addr_q     <= {addr_q[15:0], byte_data};
          addr_cnt_q <= addr_cnt_q + 3'h1;
        end else if (state_q == ST_SKIP) begin
          extra_q    <= 1'b1;
        end
      end
    end
  end

  // Write enable latch: set by its command, dropped after any protection write.
  always @(posedge core_clk) begin
    if (sys_rst | exec_reset)
      write_enable_latch <= 1'b0;
    else if (frame_done & is_wr_cmd)
      write_enable_latch <= 1'b0;
    else if (frame_done & is_write_enable_cmd & no_addr_ok)
      write_enable_latch <= 1'b1;
  end

  // One-time bits: lockdown and scheme select are only ever set.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      otp_lockdown_bit      <= `RST_LOCKDOWN;
      protect_scheme_select <= `RST_SCHEME;
    end else begin
      if (exec_secw)
        otp_lockdown_bit <= 1'b1;
      if (exec_psel)
        protect_scheme_select <= 1'b1;
    end
  end

  // Per-block lock bits, all set at power-up so every region is locked once the region scheme is selected.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi = gi + 1) begin : g_block
      always @(posedge core_clk)
        if (sys_rst)
          block_lock_q[gi] <= `RST_REGION_LOCK;
        else if (exec_glock)
          block_lock_q[gi] <= 1'b1;
        else if (exec_gunlk)
          block_lock_q[gi] <= 1'b0;
        else if ((exec_lock | exec_unlk) && tgt_block == gi)
          block_lock_q[gi] <= exec_lock;
    end
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_sector
      always @(posedge core_clk)
        if (sys_rst)
          sector_lock_q[gi] <= `RST_REGION_LOCK;
        else if (exec_glock)
          sector_lock_q[gi] <= 1'b1;
        else if (exec_gunlk)
          sector_lock_q[gi] <= 1'b0;
        else if ((exec_lock | exec_unlk) && (tgt_first | tgt_last) && tgt_sec == gi)
          sector_lock_q[gi] <= exec_lock;
    end
  endgenerate

  // Range protection: a nonzero setting covers a power-of-two span from the top.
  wire [BLOCK_AW:0] range_span = (range_protect_bits == 4'h0) ? {(BLOCK_AW+1){1'b0}} :
                                 (range_protect_bits > BLOCK_AW) ? NUM_BLOCKS[BLOCK_AW:0] :
                                 ({{BLOCK_AW{1'b0}}, 1'b1} << (range_protect_bits - 4'h1));
  wire [BLOCK_AW:0] chk_block  = {1'b0, check_addr[16 +: BLOCK_AW]};
  wire              range_hit  = (chk_block + range_span) >= NUM_BLOCKS[BLOCK_AW:0];

  // Write permission for the array engine, from exactly one scheme at a time.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      region_write_ok <= 1'b0;
      otp_write_ok    <= 1'b0;
    end else begin
      if (protect_scheme_select)
        region_write_ok <= ~region_locked(check_addr, block_lock_q, sector_lock_q);
      else
        region_write_ok <= ~range_hit;
      otp_write_ok <= ~otp_lockdown_bit;
    end
  end

  // Ready/busy output enable, changed only by frames that end on a byte boundary.
  always @(posedge core_clk) begin
    if (sys_rst)
      ready_busy_out_en <= 1'b0;
    else if (frame_done & no_addr_ok & is_rb_en)
      ready_busy_out_en <= 1'b1;
    else if (frame_done & no_addr_ok & is_rb_dis)
      ready_busy_out_en <= 1'b0;
  end

  // Reset arm survives only until the next command; the no-op just cancels it.
  always @(posedge core_clk) begin
    if (sys_rst)
      reset_armed_q <= 1'b0;
    else if (frame_done)
      reset_armed_q <= is_arm & no_addr_ok;
  end

  // Software reset: abort running work and hold off commands while recovering.
  // Recovery after a program is the longer wait, since cells may be mid-pulse.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sw_reset_pulse   <= 1'b0;
      op_abort_pulse   <= 1'b0;
      reset_recovering <= 1'b0;
      rcv_cnt_q        <= {CNT_W{1'b0}};
    end else begin
      sw_reset_pulse <= exec_reset;
      op_abort_pulse <= exec_reset & (program_active | erase_active);
      if (exec_reset) begin
        reset_recovering <= 1'b1;
        rcv_cnt_q <= program_active ? RCV_PROGRAM_CYC[CNT_W-1:0] : RCV_OTHER_CYC[CNT_W-1:0];
      end else if (rcv_cnt_q > {{(CNT_W-1){1'b0}}, 1'b1}) begin
        rcv_cnt_q <= rcv_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        rcv_cnt_q        <= {CNT_W{1'b0}};
        reset_recovering <= 1'b0;
      end
    end
  end

  // A protection write that arrived but did nothing is flagged for one cycle.
  always @(posedge core_clk) begin
    if (sys_rst)
      cmd_reject_pulse <= 1'b0;
    else
      cmd_reject_pulse <= frame_done & is_wr_cmd & ~any_exec;
  end

  // Serial output: lock status byte during the read, else ready/busy in
  // continuous program mode. The status byte repeats while clocked.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      out_shift_q <= 8'h00;
      so_out      <= 1'b0;
      so_oe_n     <= 1'b1;
    end else begin
      if (byte_valid && state_q == ST_ADDR && addr_cnt_q == 3'h2 && is_rdlock)
        out_shift_q <= {7'h00, region_locked({addr_q[15:0], byte_data},
                                             block_lock_q, sector_lock_q)};
      else if (sclk_fall && state_q == ST_READ)
        out_shift_q <= {out_shift_q[6:0], out_shift_q[7]};
      if (!cs_active) begin
        so_oe_n <= 1'b1;
      end else if (state_q == ST_READ && protect_scheme_select) begin
        if (sclk_fall) begin
          so_out  <= out_shift_q[7];
          so_oe_n <= 1'b0;
        end
      end else if (ready_busy_out_en & continuous_program_mode) begin
        so_out  <= ~dev_busy;
        so_oe_n <= 1'b0;
      end else
        so_oe_n <= 1'b1;
    end
  end

endmodule // flash_protect_cmd_logic

// [bench/flash_protect_cmd_props.sv]
/*
  Concurrent checks on the ports of the flash protection command logic.
  Assumes it is bound to that module and shares its recovery parameters.
*/
`timescale 1ns/10ps
module flash_protect_cmd_props #(
  parameter RCV_PROGRAM_CYC = 5000,
  parameter RCV_OTHER_CYC   = 1500
) (
  input wire       core_clk,
  input wire       sys_rst,
  input wire       cs_n_pin,
  input wire [3:0] range_protect_bits,
  input wire       so_oe_n,
  input wire       protect_scheme_select,
  input wire       otp_lockdown_bit,
  input wire       otp_write_ok,
  input wire       region_write_ok,
  input wire       write_enable_latch,
  input wire       sw_reset_pulse,
  input wire       op_abort_pulse,
  input wire       reset_recovering,
  input wire       cmd_reject_pulse
);
  // Counts recovery cycles; it still holds the full span on the cycle the flag drops.
  reg [15:0] rec_cnt_q;
  always @(posedge core_clk) begin
    if (sys_rst || !reset_recovering) rec_cnt_q <= 16'h0000;
    else rec_cnt_q <= rec_cnt_q + 16'h0001;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_scheme_sticky: assert property (protect_scheme_select |=> protect_scheme_select)
    else $error("scheme flag returned to zero");
  a_lockdown_sticky: assert property (otp_lockdown_bit |=> otp_lockdown_bit)
    else $error("lockdown bit was cleared");
  a_otp_follows: assert property (!$past(sys_rst) |-> otp_write_ok == !$past(otp_lockdown_bit))
    else $error("otp write permission does not follow lockdown");
  a_range_open: assert property ((!protect_scheme_select && range_protect_bits == 4'h0 && !$past(sys_rst))
    |=> (protect_scheme_select || region_write_ok)) else $error("range mode with no range bits refused a write");
  a_abort_paired: assert property (op_abort_pulse |-> sw_reset_pulse)
    else $error("abort without software reset");
  a_reset_recovers: assert property (sw_reset_pulse |-> ##[0:1] reset_recovering)
    else $error("software reset without recovery");
  a_recovery_span: assert property ($fell(reset_recovering) && !$past(sys_rst)
    |-> (rec_cnt_q == RCV_PROGRAM_CYC || rec_cnt_q == RCV_OTHER_CYC)) else $error("recovery span has a wrong length");
  a_reject_clears_wel: assert property (cmd_reject_pulse |-> ##[0:1] !write_enable_latch)
    else $error("write enable latch survived a rejected command");
  a_reject_single: assert property (cmd_reject_pulse |=> !cmd_reject_pulse)
    else $error("reject pulse longer than one cycle");
  a_oe_idle: assert property (cs_n_pin [*6] |-> so_oe_n)
    else $error("serial output driven while deselected");
endmodule // flash_protect_cmd_props

// [bench/host_link_model.sv]
/*
  Serial flash host controller model: one command per chip-select frame.
  Assumes the core clock is 8 ns; the serial clock it makes runs at 160 ns.
*/
`timescale 1ns/10ps
module host_link_model (
  input  wire  core_clk,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic si_pin,
  input  wire  so_out,
  input  wire  so_oe_n
);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin   = 1'b0;
  end

  // Sends nb bits of tx MSB first, then clocks nr bits back in; the clock stands still between frames.
  task automatic xfer(input logic [31:0] tx, input int nb, input int nr,
                      output logic [7:0] rd, output logic oe_n, output logic so);
    rd = 8'h00;
    @(posedge core_clk) cs_n_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < nb + nr; i++) begin
      if (i < nb) si_pin <= tx[31-i];
      repeat (10) @(posedge core_clk);
      if (i >= nb) rd = {rd[6:0], so_out ^ so_oe_n}; // An undriven output reads inverted.
      sclk_pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      sclk_pin <= 1'b0;
    end
    repeat (10) @(posedge core_clk);
    oe_n = so_oe_n;
    so = so_out;
    // The released data line shows the inverse so stale bits cannot pass.
    si_pin <= ~si_pin;
    cs_n_pin <= 1'b1;
    repeat (30) @(posedge core_clk);
  endtask
endmodule // host_link_model

// [bench/flash_protect_cmd_logic_test.sv]
/*
  Testbench of the flash protection command logic, driven through the host model.
  Assumes the shared defines header is on the include path.
*/
`timescale 1ns/10ps
`include "flash_protect_defines.vh"
module flash_protect_cmd_logic_test;
  logic core_clk = 1'b0, sys_rst = 1'b1, cs_n_pin, sclk_pin, si_pin;
  logic [3:0] range_bits = 4'h0;
  logic cpm = 1'b0, busy = 1'b0, prog = 1'b0, erase = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic so_out, so_oe_n, scheme, lockdown, otp_ok, reg_ok, wel, rb_en, swr, abort, recov, rej;
  int fail_count = 0, cmp_count = 0, rej_n = 0, rst_n = 0, abort_n = 0, rec_len = 0;
  logic [7:0] v;
  logic oe, so;

  always #4 core_clk = ~core_clk;

  flash_protect_cmd_logic #(.RCV_PROGRAM_CYC(20), .RCV_OTHER_CYC(8)) i_flash_protect_cmd_logic (
    .core_clk(core_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin),
    .range_protect_bits(range_bits), .continuous_program_mode(cpm), .dev_busy(busy),
    .program_active(prog), .erase_active(erase), .check_addr(addr), .so_out(so_out), .so_oe_n(so_oe_n),
    .protect_scheme_select(scheme), .otp_lockdown_bit(lockdown), .otp_write_ok(otp_ok),
    .region_write_ok(reg_ok), .write_enable_latch(wel), .ready_busy_out_en(rb_en),
    .sw_reset_pulse(swr), .op_abort_pulse(abort), .reset_recovering(recov), .cmd_reject_pulse(rej));
  host_link_model i_host_link_model (.core_clk(core_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe_n(so_oe_n));

  // Pulses are counted here because they stand for one cycle only.
  always @(posedge core_clk) begin
    if (rej === 1'b1) rej_n <= rej_n + 1;
    if (swr === 1'b1) rst_n <= rst_n + 1;
    if (abort === 1'b1) abort_n <= abort_n + 1;
    if (recov === 1'b1) rec_len <= rec_len + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmd(input logic [31:0] tx, input int nb);
    i_host_link_model.xfer(tx, nb, 0, v, oe, so);
  endtask
  task automatic wcmd(input logic [31:0] tx, input int nb);
    cmd({`OPC_WRITE_ENABLE, 24'h000000}, 8);
    cmd(tx, nb);
  endtask
  task automatic probe(input logic [23:0] a, input logic e);
    @(posedge core_clk) addr <= a;
    repeat (3) @(posedge core_clk);
    chk("region_write_ok", {31'h0, e}, {31'h0, reg_ok});
  endtask
  task automatic rd_lock(input logic [23:0] a, input logic [7:0] e);
    i_host_link_model.xfer({`OPC_LOCK_STATUS_READ, a}, 32, 8, v, oe, so);
    chk("lock_status", {24'h0, e}, {24'h0, v});
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #600us;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("scheme", 0, scheme);
    chk("lockdown", 0, lockdown);
    chk("so_oe_n", 1, so_oe_n);
    probe(24'h3F0000, 1'b1);
    range_bits <= 4'hF;
    probe(24'h3F0000, 1'b0);
    $display("Test reset and range done");
    cmd({`OPC_GANG_UNLOCK, 24'h0}, 8);
    wcmd({`OPC_GANG_UNLOCK, 24'h0}, 8);
    chk("wel", 0, wel);
    cmd({`OPC_PROTECT_SELECT, 24'h0}, 8);
    wcmd({`OPC_PROTECT_SELECT, 24'h0}, 9);
    chk("scheme", 0, scheme);
    chk("rejects", 4, rej_n);
    rd_lock(24'h050000, 8'hFF);
    wcmd({`OPC_PROTECT_SELECT, 24'h0}, 8);
    chk("scheme", 1, scheme);
    chk("wel", 0, wel);
    $display("Test scheme select done");
    probe(24'h050000, 1'b0);
    rd_lock(24'h050000, 8'h01);
    wcmd({`OPC_REGION_UNLOCK, 24'h05ABCD}, 32);
    probe(24'h05FFFF, 1'b1);
    probe(24'h060000, 1'b0);
    rd_lock(24'h051234, 8'h00);
    wcmd({`OPC_REGION_LOCK, 24'h050000}, 32);
    probe(24'h050000, 1'b0);
    wcmd({`OPC_GANG_UNLOCK, 24'h0}, 8);
    probe(24'h3F0000, 1'b1);
    wcmd({`OPC_GANG_LOCK, 24'h0}, 8);
    probe(24'h3F0000, 1'b0);
    $display("Test region locks done");
    wcmd({`OPC_SEC_REG_WRITE, 24'h0}, 8);
    chk("lockdown", 1, lockdown);
    chk("otp_write_ok", 0, otp_ok);
    wcmd({`OPC_SEC_REG_WRITE, 24'h0}, 8);
    chk("rejects", 5, rej_n);
    $display("Test lockdown done");
    cpm <= 1'b1;
    busy <= 1'b1;
    cmd({`OPC_RB_ENABLE_DEF, 24'h0}, 8);
    chk("rb_en", 1, rb_en);
    i_host_link_model.xfer(32'h0, 0, 0, v, oe, so);
    chk("rb_oe_n", 0, oe);
    chk("rb_level", 0, so);
    busy <= 1'b0;
    i_host_link_model.xfer(32'h0, 0, 0, v, oe, so);
    chk("rb_level", 1, so);
    cmd({`OPC_RB_DISABLE_DEF, 24'h0}, 8);
    i_host_link_model.xfer(32'h0, 0, 0, v, oe, so);
    chk("rb_oe_n", 1, oe);
    $display("Test ready busy done");
    cmd({`OPC_WRITE_ENABLE, 24'h0}, 8);
    cmd({`OPC_NOP_DEF, 24'h0}, 8);
    chk("wel", 1, wel);
    cmd({`OPC_RESET_ARM_DEF, 24'h0}, 8);
    cmd({`OPC_NOP_DEF, 24'h0}, 8);
    cmd({`OPC_RESET_DEF, 24'h0}, 8);
    chk("resets", 0, rst_n);
    prog <= 1'b1;
    cmd({`OPC_RESET_ARM_DEF, 24'h0}, 8);
    cmd({`OPC_RESET_DEF, 24'h0}, 8);
    repeat (30) @(posedge core_clk);
    chk("resets", 1, rst_n);
    chk("aborts", 1, abort_n);
    chk("recovery", 20, rec_len);
    prog <= 1'b0;
    erase <= 1'b1;
    cmd({`OPC_RESET_ARM_DEF, 24'h0}, 8);
    cmd({`OPC_RESET_DEF, 24'h0}, 8);
    repeat (30) @(posedge core_clk);
    chk("aborts", 2, abort_n);
    chk("recovery", 28, rec_len);
    $display("Test software reset done");
    give_verdict();
  end
endmodule // flash_protect_cmd_logic_test

bind flash_protect_cmd_logic flash_protect_cmd_props #(
  .RCV_PROGRAM_CYC(RCV_PROGRAM_CYC), .RCV_OTHER_CYC(RCV_OTHER_CYC)) i_flash_protect_cmd_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .range_protect_bits(range_protect_bits),
  .so_oe_n(so_oe_n), .protect_scheme_select(protect_scheme_select), .otp_lockdown_bit(otp_lockdown_bit),
  .otp_write_ok(otp_write_ok), .region_write_ok(region_write_ok), .write_enable_latch(write_enable_latch),
  .sw_reset_pulse(sw_reset_pulse), .op_abort_pulse(op_abort_pulse), .reset_recovering(reset_recovering),
  .cmd_reject_pulse(cmd_reject_pulse));
